// File: core/dac_volume_latches.sv
`timescale 1ns/10ps
`default_nettype none

module dac_volume_latches
  import volume_pkg::*;
(
  input  wire  logic       clk,            // 40 MHz core clock
  input  wire  logic       rst,            // Async reset, active high
  input  wire  logic       ctrl_clk,       // Serial control clock pin
  input  wire  logic       ctrl_data,      // Serial control data pin
  input  wire  logic       ctrl_sel_n,     // Serial control select, active low
  output logic [7:0]       left_atten_code,   // Applied left code
  output logic [7:0]       right_atten_code,  // Applied right code
  output logic [7:0]       master_atten_code, // Applied master code
  output atten_level_t     left_dac_channel,  // Decoded left level
  output atten_level_t     right_dac_channel, // Decoded right level
  output atten_level_t     master_level,      // Decoded master level
  output logic             reg_reset_hold     // Register reset in force
);

  // Pin synchronisers, three stages on clock and select so edge logic never sees stage one; two on data
  logic [2:0] sclk_q;        // Serial clock history
  logic [2:0] ssel_q;        // Select history
  logic [1:0] sdat_q;        // Data synchroniser

  // Serial shifter
  logic [15:0]      shift_q;    // Incoming bits
  logic [15:0]      shift_d;    // Next shift value
  logic [CNT_W-1:0] count_q;    // Bits since select fell
  logic [CNT_W-1:0] count_d;    // Next bit count

  // Pending and applied latches
  logic [7:0] pend_l_q;      // Pending left code
  logic [7:0] pend_r_q;      // Pending right code
  logic [7:0] pend_m_q;      // Pending master code
  logic [7:0] pend_l_d;      // Next pending left
  logic [7:0] pend_r_d;      // Next pending right
  logic [7:0] pend_m_d;      // Next pending master
  logic [7:0] appl_l_d;      // Next applied left
  logic [7:0] appl_r_d;      // Next applied right
  logic [7:0] appl_m_d;      // Next applied master
  logic       hold_d;        // Next reset-hold state

  // Map a code onto mute flag and half-dB attenuation
  function automatic atten_level_t decode_level(input logic [7:0] code);
    atten_level_t lvl;
    lvl.mute    = (code == ATTEN_MUTE);
    lvl.half_db = ATTEN_RESET - code;
    return lvl;
  endfunction : decode_level

  // Edge detection on synchronised pins
  wire sclk_rise = sclk_q[1] & ~sclk_q[2];     // Bit strobe
  wire ssel_rise = ssel_q[1] & ~ssel_q[2];     // End of word
  wire ssel_low  = ~ssel_q[1];                 // Word in progress

  // A word counts only when exactly sixteen bits arrived
  wire          frame_take = ssel_rise & (count_q == FRAME_COUNT);
  write_frame_t frame;
  assign frame = write_frame_t'(shift_q);

  // Address decode; while held, a write only releases the hold
  wire live      = frame_take & ~reg_reset_hold;
  wire wr_left   = live & (frame.addr == LEFT_VOLUME_ADDR);
  wire wr_right  = live & (frame.addr == RIGHT_VOLUME_ADDR);
  wire wr_master = live & (frame.addr == MASTER_VOLUME_ADDR);
  wire wr_reset  = live & (frame.addr == REGISTER_RESET_ADDR);
  wire wr_vol    = wr_left | wr_right | wr_master;
  wire apply     = wr_vol & frame.update;   // Update bit acts only now

  // Shift register and bit counter next values
  assign shift_d = (ssel_low & sclk_rise) ? {shift_q[14:0], sdat_q[1]} : shift_q;
  assign count_d = ~ssel_low ? '0 :
                   (sclk_rise & (count_q != '1)) ? count_q + 5'h01 : count_q;

  // Pending latches; register reset wins over everything
  assign pend_l_d = wr_reset ? ATTEN_RESET : wr_left   ? frame.code : pend_l_q;
  assign pend_r_d = wr_reset ? ATTEN_RESET : wr_right  ? frame.code : pend_r_q;
  assign pend_m_d = wr_reset ? ATTEN_RESET : wr_master ? frame.code : pend_m_q;

  // Applied values move together, carrying the code of this write too
  assign appl_l_d = wr_reset ? ATTEN_RESET : apply ? pend_l_d : left_atten_code;
  assign appl_r_d = wr_reset ? ATTEN_RESET : apply ? pend_r_d : right_atten_code;
  assign appl_m_d = wr_reset ? ATTEN_RESET : apply ? pend_m_d : master_atten_code;

  // Hold sets on reset write, clears on any later completed word
  assign hold_d = wr_reset ? 1'b1 : (frame_take ? 1'b0 : reg_reset_hold);

  // Pin synchronisers; select idles high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 3'h0;
      ssel_q <= 3'h7;
      sdat_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], ctrl_clk};
      ssel_q <= {ssel_q[1:0], ctrl_sel_n};
      sdat_q <= {sdat_q[0], ctrl_data};
    end
  end

  // Serial shifter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_q <= 16'h0000;
      count_q <= 5'h00;
    end else begin
      shift_q <= shift_d;
      count_q <= count_d;
    end
  end

  // Pending latches; the update bit has no flop of its own
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_l_q <= ATTEN_RESET;
      pend_r_q <= ATTEN_RESET;
      pend_m_q <= ATTEN_RESET;
    end else begin
      pend_l_q <= pend_l_d;
      pend_r_q <= pend_r_d;
      pend_m_q <= pend_m_d;
    end
  end

  // Applied codes and decoded levels, registered straight to the outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      left_atten_code   <= ATTEN_RESET;
      right_atten_code  <= ATTEN_RESET;
      master_atten_code <= ATTEN_RESET;
      left_dac_channel  <= '0;
      right_dac_channel <= '0;
      master_level      <= '0;
      reg_reset_hold    <= 1'b0;
    end else begin
      left_atten_code   <= appl_l_d;
      right_atten_code  <= appl_r_d;
      master_atten_code <= appl_m_d;
      left_dac_channel  <= decode_level(appl_l_d);
      right_dac_channel <= decode_level(appl_r_d);
      master_level      <= decode_level(appl_m_d);
      reg_reset_hold    <= hold_d;
    end
  end

  // Assertions guarding the latch behaviour
  a_pending_only: assert property (@(posedge clk) disable iff (rst)
    (wr_vol & ~frame.update) |=> $stable(left_atten_code) && $stable(right_atten_code)
                                 && $stable(master_atten_code))
    else $error("Write without update changed an applied code");

  a_update_left: assert property (@(posedge clk) disable iff (rst)
    (apply & wr_left) |=> (left_atten_code == $past(frame.code)) && (right_atten_code == $past(pend_r_q)))
    else $error("Left update did not apply pending codes");

  a_update_right: assert property (@(posedge clk) disable iff (rst)
    (apply & wr_right) |=> (right_atten_code == $past(frame.code)) && (left_atten_code == $past(pend_l_q)))
    else $error("Right update did not apply pending codes");

  a_update_master: assert property (@(posedge clk) disable iff (rst)
    (apply & wr_master) |=> (master_atten_code == $past(frame.code)))
    else $error("Master update did not apply");

  a_mute_decode: assert property (@(posedge clk) disable iff (rst)
    ##1 (left_dac_channel.mute == (left_atten_code == 8'h00))
        && (left_dac_channel.half_db == 8'hFF - left_atten_code))
    else $error("Left level decode mismatch");

  a_reg_reset: assert property (@(posedge clk) disable iff (rst)
    wr_reset |=> reg_reset_hold && (left_atten_code == 8'hFF) && (right_atten_code == 8'hFF)
                 && (master_atten_code == 8'hFF) && (pend_l_q == 8'hFF) && (pend_m_q == 8'hFF))
    else $error("Register reset did not restore defaults");

  a_hold_release: assert property (@(posedge clk) disable iff (rst)
    (reg_reset_hold & frame_take) |=> !reg_reset_hold && (left_atten_code == 8'hFF)
                                      && (pend_r_q == 8'hFF))
    else $error("Held reset not released cleanly");

  a_hold_stays: assert property (@(posedge clk) disable iff (rst)
    (reg_reset_hold & ~frame_take) |=> reg_reset_hold)
    else $error("Reset hold dropped without a write");

  a_no_update_state: assert property (@(posedge clk) disable iff (rst)
    (frame_take & ~apply) ##1 (~frame_take & ~wr_reset) |=> $stable(left_atten_code))
    else $error("Update bit acted after its write");

  // Pending store must really take the code, not only leave outputs alone
  a_pending_store: assert property (@(posedge clk) disable iff (rst)
    (wr_left & ~frame.update) |=> (pend_l_q == $past(frame.code)))
    else $error("Write without update lost its pending code");

  // A word of the wrong length is neither a write nor a release
  a_drop_bad_word: assert property (@(posedge clk) disable iff (rst)
    (ssel_rise & (count_q != FRAME_COUNT)) |=> $stable(reg_reset_hold) && $stable(left_atten_code)
                                               && $stable(right_atten_code) && $stable(master_atten_code))
    else $error("Incomplete word changed state");

  // Master decode is a separate output from the channel levels, so guard it as well
  a_master_decode: assert property (@(posedge clk) disable iff (rst)
    ##1 (master_level.mute == (master_atten_code == ATTEN_MUTE))
        && (master_level.half_db == ATTEN_RESET - master_atten_code))
    else $error("Master level decode mismatch");

  // Main scenarios
  c_stage_then_apply: cover property (@(posedge clk) disable iff (rst)
    (wr_left & ~frame.update) ##[1:1000] (wr_right & frame.update));
  c_mute: cover property (@(posedge clk) disable iff (rst) left_dac_channel.mute);
  c_reset_release: cover property (@(posedge clk) disable iff (rst)
    wr_reset ##[1:1000] (reg_reset_hold & frame_take));
  // Short or long word seen and dropped
  c_bad_word: cover property (@(posedge clk) disable iff (rst)
    ssel_rise & (count_q != FRAME_COUNT));

endmodule : dac_volume_latches

`default_nettype wire

// File: core/volume_pkg.sv
`default_nettype none

package volume_pkg;

  // Serial control word: 7-bit address then 9-bit data, MSB first
  localparam int unsigned FRAME_BITS   = 16;
  localparam int unsigned ADDR_W       = 7;
  localparam int unsigned CODE_W       = 8;
  localparam int unsigned CNT_W        = 5;

  // Register addresses
  localparam logic [6:0] LEFT_VOLUME_ADDR    = 7'h00;
  localparam logic [6:0] RIGHT_VOLUME_ADDR   = 7'h01;
  localparam logic [6:0] MASTER_VOLUME_ADDR  = 7'h08;
  localparam logic [6:0] REGISTER_RESET_ADDR = 7'h1F;

  // Field positions within the 16-bit frame
  localparam int unsigned ADDR_MSB     = 15;
  localparam int unsigned ADDR_LSB     = 9;
  localparam int unsigned UPDATE_BIT   = 8;
  localparam int unsigned CODE_MSB     = 7;

  // Reset values and decode points
  localparam logic [7:0] ATTEN_RESET   = 8'hFF;  // 0dB
  localparam logic [7:0] ATTEN_MUTE    = 8'h00;  // Infinite attenuation
  localparam logic [4:0] FRAME_COUNT   = 5'h10;  // Full word length

  // One decoded serial write
  typedef struct packed {
    logic [6:0] addr;    // Register address
    logic       update;  // Transfer all pending codes
    logic [7:0] code;    // Attenuation code
  } write_frame_t;

  // Decoded level seen by one channel
  typedef struct packed {
    logic       mute;      // Output silenced
    logic [7:0] half_db;   // Attenuation in 0.5dB units
  } atten_level_t;

endpackage : volume_pkg

`default_nettype wire

// File: tb/test_dac_volume_latches.sv
`timescale 1ns/10ps
`default_nettype none
module test_dac_volume_latches
  import volume_pkg::*;
();
  logic         clk;           // 40 MHz core clock
  logic         rst;           // Async reset, active high
  logic         c_clk;         // Serial clock pin
  logic         c_data;        // Serial data pin
  logic         sel_n;         // Serial select, active low
  logic [7:0]   l_code;        // Applied left code
  logic [7:0]   r_code;        // Applied right code
  logic [7:0]   m_code;        // Applied master code
  atten_level_t l_lvl;         // Decoded left level
  atten_level_t r_lvl;         // Decoded right level
  atten_level_t m_lvl;         // Decoded master level
  logic         hold;          // Register reset hold
  logic [7:0]   pend [3];      // Expected pending codes L, R, M
  logic [7:0]   app [3];       // Expected applied codes L, R, M
  logic         hold_m;        // Expected hold flag
  logic [7:0]   rnd;           // Random state
  logic [6:0]   addrs [4] = '{LEFT_VOLUME_ADDR, RIGHT_VOLUME_ADDR, MASTER_VOLUME_ADDR, 7'h05};
  logic [7:0]   corner [4] = '{8'h00, 8'h01, 8'hFE, 8'hFF};  // Decode end points
  int           failures;      // Mismatch count
  int           n_checks;      // Comparison count

  dac_volume_latches dut (.clk(clk), .rst(rst), .ctrl_clk(c_clk), .ctrl_data(c_data), .ctrl_sel_n(sel_n),
    .left_atten_code(l_code), .right_atten_code(r_code), .master_atten_code(m_code),
    .left_dac_channel(l_lvl), .right_dac_channel(r_lvl), .master_level(m_lvl), .reg_reset_hold(hold));

  // Free-running core clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Eight-bit LFSR, seeded at 55
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  // Expected channel level for a code
  function automatic atten_level_t lvl(input logic [7:0] c);
    atten_level_t r;           // Level being built
    r.mute    = (c == 8'h00);
    r.half_db = 8'hFF - c;
    return r;
  endfunction : lvl

  // Map address to model slot, 3 when unmapped
  function automatic int slot(input logic [6:0] a);
    return (a == LEFT_VOLUME_ADDR) ? 0 : (a == RIGHT_VOLUME_ADDR) ? 1 : (a == MASTER_VOLUME_ADDR) ? 2 : 3;
  endfunction : slot

  // Single comparison point
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic tally_and_finish;
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // Idle for n falling edges
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // Expected effect of one complete word
  task automatic model(input logic [6:0] a, input logic u, input logic [7:0] c);
    if (hold_m) hold_m = 1'b0;
    else if (a == REGISTER_RESET_ADDR) begin
      // Every register back to default, then held
      for (int i = 0; i < 3; i++) begin
        pend[i] = ATTEN_RESET;
        app[i]  = ATTEN_RESET;
      end
      hold_m = 1'b1;
    end else if (slot(a) < 3) begin
      pend[slot(a)] = c;
      if (u) app = pend;
    end
  endtask : model

  // Compare every output against the model
  task automatic compare_all;
    check({1'b0, l_code}, {1'b0, app[0]});
    check({1'b0, r_code}, {1'b0, app[1]});
    check({1'b0, m_code}, {1'b0, app[2]});
    check(l_lvl, lvl(app[0]));
    check(r_lvl, lvl(app[1]));
    check(m_lvl, lvl(app[2]));
    check({8'h00, hold}, {8'h00, hold_m});
  endtask : compare_all

  // Serial word, n bits wrapping past sixteen; phases held 4 clocks to clear the synchronisers
  task automatic send(input logic [6:0] a, input logic u, input logic [7:0] c, input int n);
    logic [15:0] w;
    w = {a, u, c};
    sel_n = 1'b0;
    idle(4);
    for (int i = 15; i > 15 - n; i--) begin
      c_data = w[(i + 16) % 16];
      idle(4);
      c_clk = 1'b1;
      idle(4);
      c_clk = 1'b0;
    end
    idle(4);
    sel_n  = 1'b1;
    c_data = ~c_data;  // Released line shows no stale bit
    idle(8);           // Outputs land 3 rising edges after select rises
    if (n == 16) model(a, u, c);
    compare_all();
  endtask : send

  // Main sequence
  initial begin
    rst = 1'b1; c_clk = 1'b0; c_data = 1'b0; sel_n = 1'b1;
    rnd = 8'h37; failures = 0; n_checks = 0; hold_m = 1'b0;
    for (int i = 0; i < 3; i++) begin
      pend[i] = ATTEN_RESET;
      app[i]  = ATTEN_RESET;
    end
    idle(20);
    rst = 1'b0;
    idle(4);
    compare_all();
    // Decode end points on each register
    for (int i = 0; i < 4; i++) send(addrs[i % 3], 1'b1, corner[i], 16);
    // Pending codes wait, then one update applies all
    send(LEFT_VOLUME_ADDR, 1'b0, 8'h40, 16);
    send(RIGHT_VOLUME_ADDR, 1'b0, 8'h41, 16);
    send(MASTER_VOLUME_ADDR, 1'b1, 8'h42, 16);
    // Random traffic, unmapped address among it
    repeat (24) begin
      rnd = lfsr(rnd);
      send(addrs[rnd[1:0]], rnd[2], lfsr(rnd), 16);
      rnd = lfsr(rnd);
    end
    // Register reset, release word, then a short word that must drop
    send(REGISTER_RESET_ADDR, 1'b0, 8'h00, 16);
    send(LEFT_VOLUME_ADDR, 1'b1, 8'h10, 16);
    send(LEFT_VOLUME_ADDR, 1'b1, 8'h20, 15);
    send(RIGHT_VOLUME_ADDR, 1'b1, 8'h30, 16);
    // Over-long word drops; a reset word while held only releases
    send(MASTER_VOLUME_ADDR, 1'b1, 8'h50, 17);
    send(REGISTER_RESET_ADDR, 1'b1, 8'h00, 16);
    send(REGISTER_RESET_ADDR, 1'b1, 8'h00, 16);
    send(MASTER_VOLUME_ADDR, 1'b1, 8'h60, 16);
    tally_and_finish();
  end
endmodule : test_dac_volume_latches
`default_nettype wire
